// ===== verilog/tod_map.svh
// Opcode patterns and field positions for the transfer opcode decoder
`ifndef TOD_MAP_SVH
`define TOD_MAP_SVH
`define TOD_OP_MOV_TO_SEG        8'h8E
`define TOD_OP_MOV_FROM_SEG      8'h8C
`define TOD_OP_TABLE_LOOKUP      8'hD7
`define TOD_OP_EA_LOAD           8'h8D
`define TOD_OP_FAR_DATA_SEG      8'hC5
`define TOD_OP_FAR_EXTRA_SEG     8'hC4
`define TOD_OP_FLAGS_TO_HIGH_ACC 8'h9F
`define TOD_OP_FLAG_PUSH         8'h9C
`define TOD_OP_HIGH_ACC_TO_FLAGS 8'h9E
`define TOD_OP_FLAG_POP          8'h9D
`define TOD_ADC_MASK         8'hFC
`define TOD_ADC_PATTERN      8'h10
`define TOD_BIT_W            0
`define TOD_BIT_D            1
`define TOD_MOD_HI           7
`define TOD_MOD_LO           6
`define TOD_REG_HI           5
`define TOD_REG_LO           3
`define TOD_RM_HI            2
`define TOD_RM_LO            0
`define TOD_SEG_ZERO_BIT     5
`endif

// ===== verilog/tod_pkg.sv
// Types for the transfer opcode decoder
package tod_pkg;
  typedef enum logic [3:0] {
    TOD_OP_NONE,
    TOD_OP_MOV_TO_SEG,
    TOD_OP_MOV_FROM_SEG,
    TOD_OP_TABLE_LOOKUP,
    TOD_OP_EA_LOAD,
    TOD_OP_FAR_DATA_SEG,
    TOD_OP_FAR_EXTRA_SEG,
    TOD_OP_FLAGS_TO_HIGH_ACC,
    TOD_OP_FLAG_PUSH,
    TOD_OP_HIGH_ACC_TO_FLAGS,
    TOD_OP_FLAG_POP,
    TOD_OP_ADC
  } tod_op_e;
endpackage

// ===== verilog/tod_decoder.sv
// Decoder for data-transfer opcodes and the add-with-carry register form
`timescale 1ns/10ps
`include "tod_map.svh"
// What this block does
// - 8E plus addressing byte: word move into segment register, reg field selects.
// - 8C plus addressing byte: word move from segment register to reg or memory.
// - D7 alone: replace low accumulator byte from table base plus that byte.
// - 8D plus addressing byte: load effective offset, no memory data access.
// - C5: selected register gets offset, data segment register gets segment word.
// - C4: selected register gets offset, extra segment register gets segment word.
// - 9F copies low flags to high accumulator byte; 9C pushes flag word.
// - 9E loads low flags from high accumulator byte; 9D pops flag word.
// - 000100dw plus addressing byte: add with carry, d picks destination, w width.
module tod_decoder (
  input  wire logic            mclk_i,
  input  wire logic            reset_i,
  input  wire logic            byte_valid_i,
  input  wire logic [7:0]      byte_i,
  output logic                 done_o,
  output tod_pkg::tod_op_e     op_o,
  output logic                 word_o,
  output logic                 to_reg_o,
  output logic [1:0]           mode_o,
  output logic [2:0]           reg_o,
  output logic [2:0]           rm_o,
  output logic                 has_modrm_o,
  output logic                 mem_access_o,
  output logic                 data_seg_dest_o,
  output logic                 extra_seg_dest_o,
  output logic                 illegal_o
);

  // ------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------
  typedef enum logic {TOD_ST_OPCODE, TOD_ST_MODRM} tod_state_e;

  tod_state_e       state_q;
  tod_pkg::tod_op_e pend_op_q;
  logic             pend_w_q;
  logic             pend_d_q;
  tod_pkg::tod_op_e dec_op;
  logic             dec_modrm;
  logic             dec_w;
  logic             dec_d;

  always_comb begin
    dec_op    = tod_pkg::TOD_OP_NONE;
    dec_modrm = 1'b0;
    dec_w     = 1'b1;
    dec_d     = 1'b1;
    unique case (byte_i)
      `TOD_OP_MOV_TO_SEG: begin
        dec_op    = tod_pkg::TOD_OP_MOV_TO_SEG;
        dec_modrm = 1'b1;
      end
      `TOD_OP_MOV_FROM_SEG: begin
        dec_op    = tod_pkg::TOD_OP_MOV_FROM_SEG;
        dec_modrm = 1'b1;
        dec_d     = 1'b0;
      end
      `TOD_OP_TABLE_LOOKUP: begin
        dec_op = tod_pkg::TOD_OP_TABLE_LOOKUP;
        dec_w  = 1'b0;
      end
      `TOD_OP_EA_LOAD: begin
        dec_op    = tod_pkg::TOD_OP_EA_LOAD;
        dec_modrm = 1'b1;
      end
      `TOD_OP_FAR_DATA_SEG: begin
        dec_op    = tod_pkg::TOD_OP_FAR_DATA_SEG;
        dec_modrm = 1'b1;
      end
      `TOD_OP_FAR_EXTRA_SEG: begin
        dec_op    = tod_pkg::TOD_OP_FAR_EXTRA_SEG;
        dec_modrm = 1'b1;
      end
      `TOD_OP_FLAGS_TO_HIGH_ACC: begin
        dec_op = tod_pkg::TOD_OP_FLAGS_TO_HIGH_ACC;
        dec_w  = 1'b0;
      end
      `TOD_OP_FLAG_PUSH:  dec_op = tod_pkg::TOD_OP_FLAG_PUSH;
      `TOD_OP_HIGH_ACC_TO_FLAGS: begin
        dec_op = tod_pkg::TOD_OP_HIGH_ACC_TO_FLAGS;
        dec_w  = 1'b0;
      end
      `TOD_OP_FLAG_POP:   dec_op = tod_pkg::TOD_OP_FLAG_POP;
      default: begin
        if ((byte_i & `TOD_ADC_MASK) == `TOD_ADC_PATTERN) begin
          dec_op    = tod_pkg::TOD_OP_ADC;
          dec_modrm = 1'b1;
          dec_w     = byte_i[`TOD_BIT_W];
          dec_d     = byte_i[`TOD_BIT_D];
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_q   <= TOD_ST_OPCODE;
      pend_op_q <= tod_pkg::TOD_OP_NONE;
      pend_w_q  <= 1'b0;
      pend_d_q  <= 1'b0;
    end else if (byte_valid_i) begin
      if (state_q == TOD_ST_OPCODE && dec_modrm) begin
        state_q   <= TOD_ST_MODRM;
        pend_op_q <= dec_op;
        pend_w_q  <= dec_w;
        pend_d_q  <= dec_d;
      end else begin
        state_q <= TOD_ST_OPCODE;
      end
    end
  end

  // ------------------------------------------------------------
  // Result outputs
  // ------------------------------------------------------------
  // Results hold until the next instruction finishes so the consumer may sample late
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      done_o        <= 1'b0;
      op_o          <= tod_pkg::TOD_OP_NONE;
      word_o        <= 1'b0;
      to_reg_o      <= 1'b0;
      mode_o        <= 2'h0;
      reg_o         <= 3'h0;
      rm_o          <= 3'h0;
      has_modrm_o   <= 1'b0;
      mem_access_o  <= 1'b0;
      data_seg_dest_o  <= 1'b0;
      extra_seg_dest_o <= 1'b0;
      illegal_o     <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (byte_valid_i && state_q == TOD_ST_OPCODE && !dec_modrm) begin
        done_o        <= 1'b1;
        op_o          <= dec_op;
        word_o        <= dec_w;
        to_reg_o      <= dec_d;
        mode_o        <= 2'h0;
        reg_o         <= 3'h0;
        rm_o          <= 3'h0;
        has_modrm_o   <= 1'b0;
        // Lookup and flag stack moves all touch memory
        mem_access_o  <= (dec_op != tod_pkg::TOD_OP_FLAGS_TO_HIGH_ACC) &&
                         (dec_op != tod_pkg::TOD_OP_HIGH_ACC_TO_FLAGS) &&
                         (dec_op != tod_pkg::TOD_OP_NONE);
        data_seg_dest_o  <= 1'b0;
        extra_seg_dest_o <= 1'b0;
        illegal_o     <= (dec_op == tod_pkg::TOD_OP_NONE);
      end else if (byte_valid_i && state_q == TOD_ST_MODRM) begin
        done_o        <= 1'b1;
        op_o          <= pend_op_q;
        word_o        <= pend_w_q;
        to_reg_o      <= pend_d_q;
        mode_o        <= byte_i[`TOD_MOD_HI:`TOD_MOD_LO];
        reg_o         <= byte_i[`TOD_REG_HI:`TOD_REG_LO];
        rm_o          <= byte_i[`TOD_RM_HI:`TOD_RM_LO];
        has_modrm_o   <= 1'b1;
        // Register mode never touches memory; effective-address load never does
        mem_access_o  <= (byte_i[`TOD_MOD_HI:`TOD_MOD_LO] != 2'h3) &&
                         (pend_op_q != tod_pkg::TOD_OP_EA_LOAD);
        data_seg_dest_o  <= (pend_op_q == tod_pkg::TOD_OP_FAR_DATA_SEG);
        extra_seg_dest_o <= (pend_op_q == tod_pkg::TOD_OP_FAR_EXTRA_SEG);
        // Segment forms need the zero bit above the two-bit select
        illegal_o     <= ((pend_op_q == tod_pkg::TOD_OP_MOV_TO_SEG) ||
                          (pend_op_q == tod_pkg::TOD_OP_MOV_FROM_SEG)) &&
                         byte_i[`TOD_SEG_ZERO_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_lookup_single;
    @(posedge mclk_i) disable iff (reset_i)
    (byte_valid_i && state_q == TOD_ST_OPCODE && byte_i == `TOD_OP_TABLE_LOOKUP)
      |=> done_o && op_o == tod_pkg::TOD_OP_TABLE_LOOKUP && !word_o;
  endproperty
  a_lookup_single: assert property (p_lookup_single)
    else $error("table lookup not done in one byte");

  sequence s_ea_start;
    byte_valid_i && state_q == TOD_ST_OPCODE && byte_i == `TOD_OP_EA_LOAD;
  endsequence
  property p_ea_no_mem;
    @(posedge mclk_i) disable iff (reset_i)
    s_ea_start ##1 byte_valid_i |=> done_o && !mem_access_o && has_modrm_o;
  endproperty
  a_ea_no_mem: assert property (p_ea_no_mem)
    else $error("address load flagged memory access");

  property p_far_data_seg;
    @(posedge mclk_i) disable iff (reset_i)
    done_o && op_o == tod_pkg::TOD_OP_FAR_DATA_SEG
      |-> data_seg_dest_o && !extra_seg_dest_o && word_o;
  endproperty
  a_far_data_seg: assert property (p_far_data_seg)
    else $error("far load wrong segment");

  property p_far_extra_seg;
    @(posedge mclk_i) disable iff (reset_i)
    done_o && op_o == tod_pkg::TOD_OP_FAR_EXTRA_SEG
      |-> extra_seg_dest_o && !data_seg_dest_o;
  endproperty
  a_far_extra_seg: assert property (p_far_extra_seg)
    else $error("far load wrong segment");

  property p_adc_bits;
    @(posedge mclk_i) disable iff (reset_i)
    (byte_valid_i && state_q == TOD_ST_OPCODE &&
     (byte_i & `TOD_ADC_MASK) == `TOD_ADC_PATTERN) ##1 byte_valid_i
      |=> op_o == tod_pkg::TOD_OP_ADC && word_o == $past(byte_i[0], 2) &&
          to_reg_o == $past(byte_i[1], 2);
  endproperty
  a_adc_bits: assert property (p_adc_bits)
    else $error("add with carry width or direction wrong");

  property p_fields;
    @(posedge mclk_i) disable iff (reset_i)
    byte_valid_i && state_q == TOD_ST_MODRM
      |=> mode_o == $past(byte_i[7:6]) && reg_o == $past(byte_i[5:3]) &&
          rm_o == $past(byte_i[2:0]);
  endproperty
  a_fields: assert property (p_fields)
    else $error("addressing byte fields wrong");

  property p_to_seg;
    @(posedge mclk_i) disable iff (reset_i)
    (byte_valid_i && state_q == TOD_ST_OPCODE && byte_i == `TOD_OP_MOV_TO_SEG) ##1
      (byte_valid_i && !byte_i[5]) |=> op_o == tod_pkg::TOD_OP_MOV_TO_SEG && !illegal_o && word_o;
  endproperty
  a_to_seg: assert property (p_to_seg)
    else $error("move to segment decode wrong");

  property p_from_seg;
    @(posedge mclk_i) disable iff (reset_i)
    (byte_valid_i && state_q == TOD_ST_OPCODE && byte_i == `TOD_OP_MOV_FROM_SEG) ##1
      (byte_valid_i && byte_i[5]) |=> illegal_o && !to_reg_o;
  endproperty
  a_from_seg: assert property (p_from_seg)
    else $error("segment zero bit not checked");

  property p_flags;
    @(posedge mclk_i) disable iff (reset_i)
    (byte_valid_i && state_q == TOD_ST_OPCODE && byte_i[7:2] == 6'h27)
      |=> done_o && !has_modrm_o && (mem_access_o == !$past(byte_i[1]));
  endproperty
  a_flags: assert property (p_flags)
    else $error("flag transfer decode wrong");

endmodule // tod_decoder

// ===== dv/tod_queue_model.sv
// Prefetch queue model that hands instruction bytes to the decoder
`timescale 1ns/10ps
module tod_queue_model (
  input  wire logic       mclk_i,
  output logic            byte_valid_o,
  output logic [7:0]      byte_o
);
  initial begin
    byte_valid_o = 1'b0;
    byte_o       = 8'h00;
  end
  // Idle cycles show the inverse byte so a stale value can never pass as fresh
  task automatic push(input logic [7:0] b, input int gap);
    repeat (gap) begin
      @(posedge mclk_i);
      byte_valid_o <= 1'b0;
      byte_o       <= ~b;
    end
    @(posedge mclk_i);
    byte_valid_o <= 1'b1;
    byte_o       <= b;
  endtask
  task automatic idle();
    @(posedge mclk_i);
    byte_valid_o <= 1'b0;
    byte_o       <= ~byte_o;
  endtask
endmodule // tod_queue_model

// ===== dv/test_tod_decoder.sv
// Self-checking testbench for the transfer opcode decoder
`timescale 1ns/10ps
module test_tod_decoder;
  logic             mclk_i = 1'b0;
  logic             reset_i = 1'b1;
  logic             valid;
  logic [7:0]       byte_q;
  logic             done_o, word_o, to_reg_o, has_modrm_o, mem_access_o;
  logic             data_seg_dest_o, extra_seg_dest_o, illegal_o;
  tod_pkg::tod_op_e op_o;
  logic [1:0]       mode_o;
  logic [2:0]       reg_o, rm_o;
  int               n_fail = 0;
  int               tests_run = 0;
  wire logic [18:0] seen = {op_o, word_o, to_reg_o, mode_o, reg_o, rm_o, has_modrm_o,
                            mem_access_o, data_seg_dest_o, extra_seg_dest_o, illegal_o};
  always #5 mclk_i = ~mclk_i;
  tod_queue_model q (.mclk_i(mclk_i), .byte_valid_o(valid), .byte_o(byte_q));
  tod_decoder tod_decoder_inst (.mclk_i(mclk_i), .reset_i(reset_i), .byte_valid_i(valid),
    .byte_i(byte_q), .done_o(done_o), .op_o(op_o), .word_o(word_o), .to_reg_o(to_reg_o),
    .mode_o(mode_o), .reg_o(reg_o), .rm_o(rm_o), .has_modrm_o(has_modrm_o),
    .mem_access_o(mem_access_o), .data_seg_dest_o(data_seg_dest_o),
    .extra_seg_dest_o(extra_seg_dest_o), .illegal_o(illegal_o));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [18:0] got, input logic [18:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [18:0] exp_of(input logic [7:0] o, input logic [7:0] m);
    tod_pkg::tod_op_e e;
    logic             adc, hm, w, d, mem, ill;
    adc = o[7:2] == 6'h04;
    hm  = adc || o inside {8'h8E, 8'h8C, 8'h8D, 8'hC5, 8'hC4};
    w   = adc ? o[0] : !(o inside {8'hD7, 8'h9F, 8'h9E});
    d   = adc ? o[1] : o != 8'h8C;
    mem = hm ? (m[7:6] != 2'h3 && o != 8'h8D) : o inside {8'hD7, 8'h9C, 8'h9D};
    case (o)
      8'h8E: e = tod_pkg::TOD_OP_MOV_TO_SEG;
      8'h8C: e = tod_pkg::TOD_OP_MOV_FROM_SEG;
      8'hD7: e = tod_pkg::TOD_OP_TABLE_LOOKUP;
      8'h8D: e = tod_pkg::TOD_OP_EA_LOAD;
      8'hC5: e = tod_pkg::TOD_OP_FAR_DATA_SEG;
      8'hC4: e = tod_pkg::TOD_OP_FAR_EXTRA_SEG;
      8'h9F: e = tod_pkg::TOD_OP_FLAGS_TO_HIGH_ACC;
      8'h9C: e = tod_pkg::TOD_OP_FLAG_PUSH;
      8'h9E: e = tod_pkg::TOD_OP_HIGH_ACC_TO_FLAGS;
      8'h9D: e = tod_pkg::TOD_OP_FLAG_POP;
      default: e = adc ? tod_pkg::TOD_OP_ADC : tod_pkg::TOD_OP_NONE;
    endcase
    ill = e == tod_pkg::TOD_OP_NONE || (o inside {8'h8E, 8'h8C} && m[5]);
    return {e, w, d, hm ? m : 8'h00, hm, mem, o == 8'hC5, o == 8'hC4, ill};
  endfunction
  // Done must pulse for exactly one cycle after the last byte of the instruction
  task automatic run(input logic [7:0] o, input logic [7:0] m, input int gap);
    logic [18:0] e;
    e = exp_of(o, m);
    q.push(o, 0);
    if (e[4]) q.push(m, gap);
    q.idle();
    #1;
    check("done", {18'h0, done_o}, 19'h1);
    check("decode", seen, e);
    @(posedge mclk_i);
    #1;
    check("done_drop", {18'h0, done_o}, 19'h0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_single();
    logic [7:0] singles [4] = '{8'h9C, 8'h9E, 8'h9D, 8'hD7};
    q.push(8'hD7, 0);
    q.push(8'h9F, 0);
    #1;
    check("lookup_b2b", seen, exp_of(8'hD7, 8'h00));
    q.idle();
    #1;
    check("flags_b2b", seen, exp_of(8'h9F, 8'h00));
    foreach (singles[i]) run(singles[i], 8'h00, 0);
  endtask
  task automatic t_modrm();
    logic [7:0] ops [5] = '{8'h8E, 8'h8C, 8'h8D, 8'hC5, 8'hC4};
    foreach (ops[i]) begin
      run(ops[i], 8'h1E, 2);
      run(ops[i], 8'hC1, 0);
    end
  endtask
  task automatic t_adc();
    for (int i = 0; i < 4; i++) begin
      run(8'h10 + 8'(i), 8'hC1, 0);
      run(8'h10 + 8'(i), 8'h45, 1);
    end
  endtask
  task automatic t_illegal();
    run(8'h8E, 8'h3A, 0);
    run(8'h8C, 8'hE0, 0);
    run(8'h90, 8'h00, 0);
  endtask
  // An opcode cut short by reset must not swallow the next byte as its addressing byte
  task automatic t_reset();
    q.push(8'h8D, 0);
    q.idle();
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    check("reset_state", {seen[18:1], done_o}, 19'h0);
    @(posedge mclk_i);
    reset_i <= 1'b0;
    run(8'hD7, 8'h00, 0);
  endtask
  task automatic summarize();
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_single();
    t_modrm();
    t_adc();
    t_illegal();
    t_reset();
    summarize();
  end
  // The whole run needs about 120 cycles; forty times that means a hang
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_fail++;
    summarize();
  end
endmodule // test_tod_decoder
